// ### verilog/adc_config_readout.sv
// Converter configuration word, conversion sequencing and result readout
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Status pin is cascade input when D5 is 0, status output when 1.
// - D4 low enables auto nap between cycles; ignored while D9 is 0.
// - D3 low enters nap; high resumes; wake-up forces D3 high.
// - D2 low enters deep power-down; high resumes; wake-up forces D2 high.
// - D1 high puts the channel marker on the 17th serial clock.
// - Single-input variant ignores D1 and reads it back as 0.
// - D0 low is software reset: word back to all ones, sequencer restarts.
// - Result loads at conversion end, presented from next frame fall.
// - Sampling ends at trigger fall, or third conversion clock after done.
// - Frame before completion reads previous result, after reads current.
// - Result shifts as 16-bit straight binary, MSB first.
// - After result: marker if enabled, then zeros until frame ends.
// - Serial output driven only while frame is low.
// - Every frame other than a config read or the first after a reset outputs as many leading result bits as clocks supplied, up to 16.
// - First frame after any reset outputs all ones.
// - Code is unsigned binary, one step is reference over 65536.
// - Marker bit is 0 for channel 0 and 1 for channel 1.
// - Configuration write takes effect at the 16th falling clock edge.
module adc_config_readout
  import adc_cfg_pkg::*;
#(
  parameter logic DUAL_INPUT = 1'b1
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic sclk_in,
  input wire logic frame_sync_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_n_out,
  input wire logic conversion_trigger_n_in,
  input wire logic [15:0] analog_code_in,
  input wire logic channel_in,
  input wire logic cascade_serial_in,
  output logic status_out,
  output logic status_oe_n_out,
  output logic nap_out,
  output logic deep_powerdown_out,
  output logic auto_nap_out,
  output logic converting_out,
  output logic [11:0] converter_configuration_word_out
);

  // ----------------------------------------
  // Link side and crossings
  // ----------------------------------------

  link_xfer_if x ();

  serial_link u_link (
    .sclk_in(sclk_in),
    .reset_n_in(reset_n_in),
    .frame_sync_n_in(frame_sync_n_in),
    .sdi_in(sdi_in),
    .sdo_out(sdo_out),
    .sdo_oe_n_out(sdo_oe_n_out),
    .x(x.link)
  );

  logic [3:0] sync_d, sync_q;

  // Trigger pin, serial clock level and the two link toggles
  assign sync_d = {conversion_trigger_n_in, sclk_in, x.cmd_tgl, x.frame_tgl};

  pin_sync #(
    .W(4),
    .INIT(4'hC)
  ) u_sync (
    .clk_in(sys_clk_in),
    .rst_n_in(reset_n_in),
    .d_in(sync_d),
    .q_out(sync_q)
  );

  logic trig_q, sclk_q, cmd_tgl_q, frame_tgl_q;

  // Previous synchronised values for edge detection
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {trig_q, sclk_q, cmd_tgl_q, frame_tgl_q} <= 4'hC;
    end else begin
      {trig_q, sclk_q, cmd_tgl_q, frame_tgl_q} <= sync_q;
    end
  end

  logic trig_fall, sclk_rise, cmd_evt, frame_evt;

  // Events seen in the system clock domain
  assign trig_fall = trig_q & ~sync_q[3];
  assign sclk_rise = ~sclk_q & sync_q[2];
  assign cmd_evt = cmd_tgl_q ^ sync_q[1];
  assign frame_evt = frame_tgl_q ^ sync_q[0];

  // ----------------------------------------
  // Configuration word
  // ----------------------------------------

  logic [11:0] cfg_q, cfg_d;
  logic soft_rst;

  // Write with the reset bit low acts as a system reset
  assign soft_rst = cmd_evt && x.cmd == CMD_WR_CFG && !x.cmd_data[CFG_RUN];

  // Next configuration word from the executed command
  always_comb begin
    cfg_d = cfg_q;
    if (cmd_evt) begin
      case (x.cmd)
        CMD_WAKE: begin
          cfg_d[CFG_NAP_OFF] = 1'b1;
          cfg_d[CFG_DEEP_OFF] = 1'b1;
        end
        CMD_DEFAULT: cfg_d = CFG_RESET;
        CMD_WR_CFG: cfg_d = soft_rst ? CFG_RESET : x.cmd_data;
        default: cfg_d = cfg_q;
      endcase
    end
  end

  // Configuration register
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg_q <= CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  logic chain_mode, manual_trig, conversion_clock_source_internal, tag_enable;
  logic nap_mode, deep_mode, auto_nap, powered_down;

  // Decoded configuration fields
  assign chain_mode = ~cfg_q[CFG_STATUS_OUT];
  assign manual_trig = cfg_q[CFG_TRIG_MAN];
  assign conversion_clock_source_internal = cfg_q[CFG_CONVERSION_CLOCK_SOURCE_INT];
  assign tag_enable = DUAL_INPUT & cfg_q[CFG_TAG_EN];
  assign nap_mode = ~cfg_q[CFG_NAP_OFF];
  assign deep_mode = ~cfg_q[CFG_DEEP_OFF];
  assign auto_nap = manual_trig & ~cfg_q[CFG_AUTONAP_OFF];
  assign powered_down = nap_mode | deep_mode;

  // ----------------------------------------
  // Conversion clock
  // ----------------------------------------

  logic half_q, conversion_clock_source_tick;

  // Divide the serial clock by two when it is the conversion clock
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      half_q <= 1'b0;
    end else if (sclk_rise) begin
      half_q <= ~half_q;
    end
  end

  assign conversion_clock_source_tick = conversion_clock_source_internal | (sclk_rise & half_q);

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------

  conv_state_t state_q, state_d;
  logic [5:0] cnt_q, cnt_d;
  logic [5:0] conv_len;
  logic conv_done;

  // Conversion takes longer when auto nap is active
  assign conv_len = auto_nap ? CONV_NAP_CCLKS : CONV_CCLKS;
  assign conv_done = state_q == ST_CONVERT && conversion_clock_source_tick && cnt_q == conv_len - 6'h01;

  // Next state and cycle count
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        cnt_d = 6'h00;
        if (powered_down) begin
          state_d = ST_POWERDOWN;
        end else if (!manual_trig) begin
          state_d = ST_SAMPLE;
        end else if (trig_fall) begin
          state_d = ST_CONVERT;
        end
      end
      ST_SAMPLE: begin
        if (powered_down || manual_trig) begin
          state_d = ST_IDLE;
          cnt_d = 6'h00;
        end else if (conversion_clock_source_tick) begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == EOS_AUTO_CCLKS - 6'h01) begin
            state_d = ST_CONVERT;
            cnt_d = 6'h00;
          end
        end
      end
      ST_CONVERT: begin
        if (conversion_clock_source_tick) begin
          cnt_d = cnt_q + 6'h01;
        end
        if (conv_done) begin
          state_d = manual_trig ? ST_IDLE : ST_SAMPLE;
          cnt_d = 6'h00;
        end
      end
      ST_POWERDOWN: begin
        cnt_d = 6'h00;
        if (!powered_down) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d = 6'h00;
      end
    endcase
  end

  // Sequencer registers, restarted by software reset
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
      cnt_q <= 6'h00;
    end else if (soft_rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 6'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------
  // Result holding register and reset marker
  // ----------------------------------------

  logic [15:0] result_holding_register_q;
  logic tag_q, ones_q, int_q;

  // Result and its channel load at conversion end
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      result_holding_register_q <= 16'h0000;
      tag_q <= 1'b0;
    end else if (conv_done) begin
      result_holding_register_q <= analog_code_in;
      tag_q <= channel_in;
    end
  end

  // All-ones marker and attention flag; a set wins over the frame clear
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ones_q <= 1'b1;
      int_q <= 1'b0;
    end else begin
      ones_q <= soft_rst | (ones_q & ~frame_evt);
      int_q <= conv_done | (int_q & ~frame_evt & ~soft_rst);
    end
  end

  // Word published to the link; stable around frame fall by host spacing
  assign x.word = ones_q ? ALL_ONES : result_holding_register_q;
  assign x.ones = ones_q;
  assign x.tag = tag_q;
  assign x.tag_en = tag_enable;
  assign x.cfg = {cfg_q[11:2], tag_enable, cfg_q[0]};

  // ----------------------------------------
  // Status pin and power outputs
  // ----------------------------------------

  logic status_level, status_q;
  logic [3:0] pwr_q;

  // Busy level or attention flag, then the programmed polarity
  assign status_level = cfg_q[CFG_EOC_SEL] ? (state_q == ST_CONVERT) : int_q;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_q <= 1'b1;
      pwr_q <= 4'h0;
    end else begin
      status_q <= cfg_q[CFG_POL_LOW] ? ~status_level : status_level;
      pwr_q <= {nap_mode, deep_mode, auto_nap & (state_q != ST_CONVERT),
                state_q == ST_CONVERT};
    end
  end

  // Pin is driven only when it is not the cascade input
  assign status_out = status_q;
  assign status_oe_n_out = chain_mode;
  assign nap_out = pwr_q[3];
  assign deep_powerdown_out = pwr_q[2];
  assign auto_nap_out = pwr_q[1];
  assign converting_out = pwr_q[0];
  assign converter_configuration_word_out = x.cfg;
endmodule
`default_nettype wire

// ### verilog/adc_cfg_pkg.sv
// Constants shared by the converter configuration and readout block
package adc_cfg_pkg;
  // ----------------------------------------
  // Configuration word layout
  // ----------------------------------------
  localparam int CFG_W = 12;
  localparam logic [11:0] CFG_RESET = 12'hFFF;
  localparam int CFG_CONVERSION_CLOCK_SOURCE_INT = 10;
  localparam int CFG_TRIG_MAN = 9;
  localparam int CFG_POL_LOW = 7;
  localparam int CFG_EOC_SEL = 6;
  localparam int CFG_STATUS_OUT = 5;
  localparam int CFG_AUTONAP_OFF = 4;
  localparam int CFG_NAP_OFF = 3;
  localparam int CFG_DEEP_OFF = 2;
  localparam int CFG_TAG_EN = 1;
  localparam int CFG_RUN = 0;

  // ----------------------------------------
  // Serial commands and frame counts
  // ----------------------------------------
  localparam logic [3:0] CMD_WAKE = 4'hB;
  localparam logic [3:0] CMD_RD_CFG = 4'hC;
  localparam logic [3:0] CMD_WR_CFG = 4'hE;
  localparam logic [3:0] CMD_DEFAULT = 4'hF;
  localparam int RESULT_W = 16;
  localparam logic [4:0] CMD_LAST_BIT = 5'h03;
  localparam logic [4:0] WORD_LAST_BIT = 5'h0F;
  localparam logic [4:0] TAG_SLOT = 5'h10;
  localparam logic [4:0] CNT_MAX = 5'h1F;
  localparam logic [15:0] ALL_ONES = 16'hFFFF;

  // ----------------------------------------
  // Conversion clock counts
  // ----------------------------------------
  localparam logic [5:0] CONV_CCLKS = 6'h24;
  localparam logic [5:0] CONV_NAP_CCLKS = 6'h30;
  localparam logic [5:0] EOS_AUTO_CCLKS = 6'h03;

  // Conversion sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SAMPLE = 4'h2,
    ST_CONVERT = 4'h4,
    ST_POWERDOWN = 4'h8
  } conv_state_t;
endpackage

// ### verilog/link_xfer_if.sv
// Signals passed between the core and the serial link logic
`timescale 1ns/100ps
`default_nettype none
interface link_xfer_if;
  logic [15:0] word;
  logic ones;
  logic tag;
  logic tag_en;
  logic [11:0] cfg;
  logic cmd_tgl;
  logic [3:0] cmd;
  logic [11:0] cmd_data;
  logic frame_tgl;
  modport link (input word, ones, tag, tag_en, cfg,
                output cmd_tgl, cmd, cmd_data, frame_tgl);
  modport core (output word, ones, tag, tag_en, cfg,
                input cmd_tgl, cmd, cmd_data, frame_tgl);
endinterface
`default_nettype wire

// ### verilog/pin_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] s1_q, s2_q, s3_q, q_q, q_d;

  // Take stage three only where stages two and three agree
  assign q_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & q_q);
  assign q_out = q_q;

  // Synchroniser chain
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      q_q <= INIT;
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q <= q_d;
    end
  end
endmodule
`default_nettype wire

// ### verilog/serial_link.sv
// Serial link logic clocked by the host serial clock
`timescale 1ns/100ps
`default_nettype none
module serial_link
  import adc_cfg_pkg::*;
(
  input wire logic sclk_in,
  input wire logic reset_n_in,
  input wire logic frame_sync_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_n_out,
  link_xfer_if.link x
);
  logic frame_rst_n;
  logic [4:0] cnt_q;
  logic [15:0] rx_q;
  logic [15:0] word_q;
  logic ones_q, tag_q, tag_en_q, sdo_q, rd_cfg_q;
  logic [11:0] cfg_q;
  logic [3:0] cmd_now, idx_now;
  logic first_bit, next_bit, rd_cfg_now;
  logic ones_now;
  logic [15:0] word_now;

  // Frame logic is held cleared while the frame is inactive
  assign frame_rst_n = reset_n_in & ~frame_sync_n_in;
  assign cmd_now = {rx_q[2:0], sdi_in};
  assign idx_now = 4'hE - cnt_q[3:0];
  assign rd_cfg_now = (cnt_q == CMD_LAST_BIT) ? (cmd_now == CMD_RD_CFG) : rd_cfg_q;
  // The snapshot lands on the first edge, so that edge takes the live word
  assign ones_now = (cnt_q == 5'h00) ? x.ones : ones_q;
  assign word_now = (cnt_q == 5'h00) ? x.word : word_q;

  // First bit is shown before any clock edge; word is stable by host spacing
  assign first_bit = x.ones | x.word[RESULT_W-1];
  // Bit for the slot after the coming edge
  assign next_bit = (cnt_q < WORD_LAST_BIT) ?
    (ones_now ? 1'b1 : (rd_cfg_now ? cfg_q[idx_now] : word_now[idx_now])) :
    (cnt_q == WORD_LAST_BIT) ? (tag_en_q & tag_q) :
    1'b0;

  // Output held low while the frame is inactive
  assign sdo_out = ~frame_sync_n_in & ((cnt_q == 5'h00) ? first_bit : sdo_q);
  assign sdo_oe_n_out = frame_sync_n_in;

  // Bit counter, receive shifter and snapshot of the published word
  always_ff @(negedge sclk_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt_q <= 5'h00;
      rx_q <= 16'h0000;
      word_q <= 16'h0000;
      {ones_q, tag_q, tag_en_q, sdo_q, rd_cfg_q} <= 5'h00;
      cfg_q <= 12'h000;
    end else begin
      cnt_q <= (cnt_q == CNT_MAX) ? CNT_MAX : cnt_q + 5'h01;
      rx_q <= {rx_q[14:0], sdi_in};
      sdo_q <= next_bit;
      if (cnt_q == 5'h00) begin
        word_q <= x.word;
        ones_q <= x.ones;
        tag_q <= x.tag;
        tag_en_q <= x.tag_en;
        cfg_q <= x.cfg;
      end
      if (cnt_q == CMD_LAST_BIT) begin
        rd_cfg_q <= (cmd_now == CMD_RD_CFG);
      end
    end
  end

  // Command events toggle across to the core
  always_ff @(negedge sclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      x.cmd_tgl <= 1'b0;
      x.frame_tgl <= 1'b0;
      x.cmd <= 4'h0;
      x.cmd_data <= 12'h000;
    end else if (!frame_sync_n_in) begin
      if (cnt_q == 5'h00) begin
        x.frame_tgl <= ~x.frame_tgl;
      end
      if (cnt_q == CMD_LAST_BIT && (cmd_now == CMD_WAKE || cmd_now == CMD_DEFAULT)) begin
        x.cmd_tgl <= ~x.cmd_tgl;
        x.cmd <= cmd_now;
      end
      if (cnt_q == WORD_LAST_BIT && rx_q[14:11] == CMD_WR_CFG) begin
        x.cmd_tgl <= ~x.cmd_tgl;
        x.cmd <= CMD_WR_CFG;
        x.cmd_data <= {rx_q[10:0], sdi_in};
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/adc_config_readout_asserts.sv
// Port checks for the converter configuration and readout block
`timescale 1ns/100ps
`default_nettype none
module adc_config_readout_asserts
  import adc_cfg_pkg::*;
#(
  parameter logic DUAL_INPUT = 1'b1
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic sclk_in,
  input wire logic frame_sync_n_in,
  input wire logic sdo_out,
  input wire logic sdo_oe_n_out,
  input wire logic status_oe_n_out,
  input wire logic nap_out,
  input wire logic deep_powerdown_out,
  input wire logic auto_nap_out,
  input wire logic converting_out,
  input wire logic [11:0] converter_configuration_word_out
);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  logic [5:0] conv_cnt_q;
  logic dirty_q;
  logic [11:0] cfg_q;
  logic [4:0] bit_cnt_q;
  wire logic [11:0] cfg = converter_configuration_word_out;
  // Conversion length, spoilt by a word change mid-conversion
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      conv_cnt_q <= 6'h00;
      dirty_q <= 1'b0;
      cfg_q <= CFG_RESET;
    end else begin
      conv_cnt_q <= converting_out ? conv_cnt_q + 6'h01 : 6'h00;
      dirty_q <= converting_out && (dirty_q || cfg != cfg_q);
      cfg_q <= cfg;
    end
  end
  // Falling serial edges since the frame opened
  always_ff @(negedge sclk_in or posedge frame_sync_n_in) begin
    if (frame_sync_n_in) begin
      bit_cnt_q <= 5'h00;
    end else if (bit_cnt_q != CNT_MAX) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_oe_follows_frame: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in) sdo_oe_n_out == frame_sync_n_in)
    else $error("sdo enable differs from frame");
  a_sdo_idle_low: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in) frame_sync_n_in |-> !sdo_out)
    else $error("sdo high outside a frame");
  a_status_pin_dir: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in) status_oe_n_out == !cfg[CFG_STATUS_OUT])
    else $error("status pin direction wrong");
  a_nap_entry: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in) !cfg[CFG_NAP_OFF] [*2] |-> nap_out)
    else $error("nap not entered");
  a_deep_resume: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in) $rose(cfg[CFG_DEEP_OFF]) |=> !deep_powerdown_out)
    else $error("deep power-down not left");
  a_autonap_cause: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    auto_nap_out |-> $past(cfg[CFG_TRIG_MAN]) && !$past(cfg[CFG_AUTONAP_OFF]))
    else $error("auto nap without its setting");
  a_cfg_reset_val: assert property (@(posedge sys_clk_in)
    !reset_n_in |-> cfg == CFG_RESET)
    else $error("word not all ones in reset");
  a_conv_length: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in) $fell(converting_out) && cfg[CFG_CONVERSION_CLOCK_SOURCE_INT] && !dirty_q
    |-> conv_cnt_q == ((cfg[CFG_TRIG_MAN] && !cfg[CFG_AUTONAP_OFF]) ? CONV_NAP_CCLKS : CONV_CCLKS))
    else $error("conversion length wrong");
  a_trail_zero: assert property (@(posedge sclk_in)
    disable iff (!reset_n_in || frame_sync_n_in) bit_cnt_q > TAG_SLOT |-> !sdo_out)
    else $error("trailing bit not zero");
  a_tag_off: assert property (@(posedge sclk_in)
    disable iff (!reset_n_in || frame_sync_n_in)
    bit_cnt_q == TAG_SLOT && !(cfg[CFG_TAG_EN] && DUAL_INPUT) |-> !sdo_out)
    else $error("marker shown while disabled");
  // Main scenarios reached
  c_conv_done: cover property (@(posedge sys_clk_in) $fell(converting_out));
  c_tag_seen: cover property (@(posedge sclk_in) bit_cnt_q == TAG_SLOT && sdo_out);
  c_auto_nap: cover property (@(posedge sys_clk_in) auto_nap_out);
endmodule
bind adc_config_readout adc_config_readout_asserts #(.DUAL_INPUT(DUAL_INPUT)) u_chk (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .sclk_in(sclk_in),
  .frame_sync_n_in(frame_sync_n_in), .sdo_out(sdo_out), .sdo_oe_n_out(sdo_oe_n_out),
  .status_oe_n_out(status_oe_n_out), .nap_out(nap_out),
  .deep_powerdown_out(deep_powerdown_out), .auto_nap_out(auto_nap_out),
  .converting_out(converting_out),
  .converter_configuration_word_out(converter_configuration_word_out));
`default_nettype wire

// ### bench/host_serial_model.sv
// Behavioural host acting as serial master on the readout link
`timescale 1ns/100ps
`default_nettype none
module host_serial_model (
  output logic sclk_out,
  output logic frame_sync_n_out,
  output logic sdi_out,
  input wire logic sdo_in
);
  // Serial clock parks high outside frames and never runs free
  initial begin
    sclk_out = 1'b1;
    frame_sync_n_out = 1'b0;
    sdi_out = 1'b0;
    #2 frame_sync_n_out = 1'b1; // Parks high just after reset falls, giving real clearing edges
  end
  // ----------------------------------------
  // One framed transfer, 48 ns clock period
  // ----------------------------------------
  // Sends tx MSB first, samples sdo just before each falling edge
  task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
    rx = 24'h000000;
    #7.3 frame_sync_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi_out = tx[23 - i];
      #24 rx[23 - i] = sdo_in;
      sclk_out = 1'b0;
      #24 sclk_out = 1'b1;
    end
    #24 frame_sync_n_out = 1'b1;
    sdi_out = ~sdi_out; // Released line shows the inverse of its last bit
    #200; // Gap keeps the next frame fall clear of conversion ends
  endtask
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the converter configuration and readout block
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import adc_cfg_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b1;
  logic trig_n = 1'b1;
  logic [15:0] code = 16'h0000;
  logic chan = 1'b0;
  logic sclk, frame_sync_n, sdi, sdo, sdo_oe_n, status, status_oe_n;
  logic nap, deep, auto_nap, conv;
  logic [11:0] cfg;
  logic [23:0] rx;
  logic [15:0] codes [3] = '{16'h0000, 16'hFFFF, 16'h8000};
  int err_total = 0;
  int cmp_count = 0;
  wire logic sdo_line = sdo_oe_n ? 1'bz : sdo;
  always #10 sys_clk = ~sys_clk;
  // ----------------------------------------
  // Design and host
  // ----------------------------------------
  adc_config_readout #(.DUAL_INPUT(1'b1)) i_adc_config_readout (
    .sys_clk_in(sys_clk), .reset_n_in(reset_n), .sclk_in(sclk),
    .frame_sync_n_in(frame_sync_n), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_n_out(sdo_oe_n),
    .conversion_trigger_n_in(trig_n), .analog_code_in(code), .channel_in(chan),
    .cascade_serial_in(1'b0), .status_out(status), .status_oe_n_out(status_oe_n),
    .nap_out(nap), .deep_powerdown_out(deep), .auto_nap_out(auto_nap),
    .converting_out(conv), .converter_configuration_word_out(cfg));
  host_serial_model i_host_serial_model (
    .sclk_out(sclk), .frame_sync_n_out(frame_sync_n), .sdi_out(sdi), .sdo_in(sdo_line));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // One frame: 16-bit command word, n clocks, answer in rx
  task automatic xf(input logic [15:0] tx, input int n);
    i_host_serial_model.xfer({tx, 8'h00}, n, rx);
  endtask
  // Trigger pulse only between frames, clear of serial traffic
  task automatic trig(input logic [15:0] c, input logic ch);
    @(posedge sys_clk);
    #1;
    code = c;
    chan = ch;
    trig_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    trig_n = 1'b1;
  endtask
  // Bounded wait for the converting flag; running out counts as a mismatch
  task automatic wait_conv(input logic v);
    int k;
    k = 0;
    while (conv !== v && k < 200) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    if (k == 200) err_total++;
  endtask
  // Watchdog against a hung run
  initial begin
    #300000;
    err_total++;
    finish_test();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    #1 reset_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    chk(24'(cfg), 24'(CFG_RESET));
    chk({21'h000000, status, status_oe_n, sdo_oe_n}, 24'h000005);
    xf(16'hD000, 16);
    chk(rx, 24'hFFFF00);
    foreach (codes[i]) begin
      trig(codes[i], 1'b0);
      wait_conv(1'b1);
      wait_conv(1'b0);
      xf(16'hD000, 24); // Marker slot needs more than 16 clocks
      chk(rx, {codes[i], 8'h00});
    end
    xf({CMD_DEFAULT, 12'h000}, 4);
    chk(rx, 24'h800000);
    trig(16'h1234, 1'b1);
    wait_conv(1'b1);
    chk({22'h000000, conv, status}, 24'h000002);
    xf(16'hD000, 16); // Frame opens mid-conversion, well clear of its end
    chk(rx, 24'h800000);
    wait_conv(1'b0);
    xf(16'hD000, 24);
    chk(rx, {16'h1234, 8'h80});
    xf({CMD_WR_CFG, 12'hFF1}, 15);
    chk(rx, {16'h1234, 8'h00});
    chk(24'(cfg), 24'h000FFF);
    xf({CMD_WR_CFG, 12'hFF1}, 16);
    chk(24'(cfg), 24'h000FF1);
    chk({22'h000000, nap, deep}, 24'h000003);
    xf({CMD_RD_CFG, 12'h000}, 16);
    chk(rx, {4'h1, 12'hFF1, 8'h00});
    xf({CMD_WAKE, 12'h000}, 4);
    chk(24'(cfg), 24'h000FFD);
    chk({22'h000000, nap, deep}, 24'h000000);
    xf(16'hD000, 24);
    chk(rx, {16'h1234, 8'h00});
    xf({CMD_WR_CFG, 12'hFCD}, 16);
    chk({22'h000000, status_oe_n, auto_nap}, 24'h000003);
    xf({CMD_WR_CFG, 12'hDCD}, 16);
    chk(24'(auto_nap), 24'h000000);
    wait_conv(1'b1);
    chk(24'(conv), 24'h000001);
    xf({CMD_WR_CFG, 12'hDCC}, 16);
    chk(24'(cfg), 24'h000FFF);
    xf(16'hD000, 16);
    chk(rx, 24'hFFFF00);
    finish_test();
  end
endmodule
`default_nettype wire
